// [pch_cfg.svh]
// Timing, field and code constants of the programming-mode command handler.
// Assumes a 10 ns system clock; included by its bare name.
`ifndef PCH_CFG_SVH
`define PCH_CFG_SVH

`define PCH_CLK_PERIOD_NS 10
`define PCH_BIT_PERIOD_NS 500000
`define PCH_SYNC_MASK_NS 20000
`define PCH_START_DELAY_NS 1000000

`define PCH_CRC_SEED 3'h7
`define PCH_CRC_POLY 3'h3
`define PCH_START_BITS 3'h2
`define PCH_OWN_ADDR 3'h1
`define PCH_ZERO_RUN 3'h5
`define PCH_ONE_RUN 5'h1F
`define PCH_SHORT_BITS 5'h09
`define PCH_LONG_BITS 5'h13
`define PCH_CRC_BITS 5'h03
`define PCH_FC_POS 5'h05

`define PCH_FC_READ 3'h2
`define PCH_FC_WRITE 3'h3
`define PCH_FC_BURN 3'h4
`define PCH_FC_ENTER 3'h7

`define PCH_RC_OK 10'h1E1
`define PCH_RC_ERR 10'h1E2
`define PCH_BURN_ACK 10'h2AA
`define PCH_ENTER_ACK 10'h0CA

`define PCH_ERR_FRAME 4'h1
`define PCH_ERR_CRC 4'h2
`define PCH_ERR_RANGE 4'h5
`define PCH_ERR_LOCK 4'h6

`define PCH_NVM_BYTES 5'h10
`define PCH_STATE_BYTE 4'hF
`define PCH_SHORT_WORDS 2'h2
`define PCH_LONG_WORDS 2'h3

`endif

// [pch_cmd_handler.sv]
// Programming-mode command receiver and responder on the sensor supply line.
// Assumes i_sync_pulse is a one-cycle pulse per detected supply sync pulse,
// and that an outside transmitter sends each reply word with parity and timing.
`timescale 1ns/1ps
`include "pch_cfg.svh"
// Contract
// - A 3-bit checksum covers all message bits except start and sync bits.
// - Checksum polynomial x^3+x+1, register seeded with 111 before each message.
// - Bits enter checksum LSB first in arrival order, then three zeros.
// - Received checksum arrives MSB first; mismatch answers error with fault 0010.
// - Fixed sync masking time in programming mode and entry; mask select ignored.
// - Missing sync bit abandons command; next sync gets short framing fault 0001.
// - Code 100 starts burn, answers 0x2AA or error; 101, 110, 000, 001 silent.
// - Code 111 enters programming mode, answers 0x0CA; silent if received in error.
// - Long 010 reads: containing byte, then next byte; error gives fault then zero.
// - Long 011 writes nibble; answers byte after write then pointer; else fault, zero.
// - Reply code 0x1E1 for correct reception, 0x1E2 for a transmission error.
// - Byte address is pointer without its low bit; second byte is pointer plus 2.
// - Reading the last array byte returns zero as second byte.
// - Only fault numbers 0001, 0010, 0101 and 0110 are ever produced.
// - Commands for another target address are silently ignored; code still answers fault 0010 on checksum mismatch, 0001 on missing sync.
// - Fault number sits in low 4 bits of second reply word, other bits zero.
// - After accepting burn command, wait a fixed delay before burning starts.
// - Sync pulses are ignored during the burn; master should not send any.
// - Burn success refreshes shadows from memory and sets the load-done flag.
// - A sync pulse in a bit period is one, a missing pulse is zero.
// - Frame starts after 5 zeros or 31 ones, then 010, address, code, fields, checksum.
// - A one-valued sync bit precedes each three frame bits; the receiver strips them.
// - After a good command, one reply word per following sync, 2 or 3 words.
module pch_cmd_handler #(
  parameter int unsigned P_BIT_CYC = `PCH_BIT_PERIOD_NS / `PCH_CLK_PERIOD_NS,
  parameter int unsigned P_START_CYC = `PCH_START_DELAY_NS / `PCH_CLK_PERIOD_NS,
  parameter int unsigned P_MASK_CYC =
    (`PCH_SYNC_MASK_NS + `PCH_CLK_PERIOD_NS - 1) / `PCH_CLK_PERIOD_NS
) (
  input wire logic i_clk, // System clock, 100 MHz
  input wire logic i_rst_n, // Asynchronous reset, active low
  input wire logic i_sync_pulse, // One-cycle pulse per supply sync pulse
  input wire logic i_array_locked, // Shadow array write protected
  input wire logic i_burn_done, // One-cycle pulse: memory burn finished
  input wire logic i_burn_ok, // Burn result, valid with i_burn_done
  input wire logic i_load_valid, // Shadow byte load from memory
  input wire pch_pkg::pch_baddr_t i_load_addr, // Shadow byte load address
  input wire pch_pkg::pch_byte_t i_load_data, // Shadow byte load data
  input wire logic i_load_done, // One-cycle pulse: shadow refresh finished
  output logic o_resp_valid, // One-cycle pulse: send o_resp_word now
  output pch_pkg::pch_word_t o_resp_word, // Reply word
  output logic o_prog_mode, // Programming mode active
  output logic o_burn_start, // One-cycle pulse: begin memory burn
  output logic o_burning, // Burn in progress
  output logic o_refresh_req, // One-cycle pulse: reload shadows from memory
  output logic o_otp_load_done_flag // Burn and refresh completed
);
  import pch_pkg::*;

  // Mask must stay shorter than the bit period, or every second sync is lost
  localparam logic [11:0] MASK_W = 12'(P_MASK_CYC);
  localparam logic [23:0] HALF_W = 24'(P_BIT_CYC / 2);
  localparam logic [23:0] ZERO_W = 24'(P_BIT_CYC + P_BIT_CYC / 2);
  localparam logic [23:0] START_W = 24'(P_START_CYC - 1);

  function automatic logic [2:0] crc_step(input logic [2:0] c, input logic b);
    crc_step = {c[1:0], b} ^ (c[2] ? `PCH_CRC_POLY : 3'h0);
  endfunction

  function automatic pch_byte_t map_byte(input pch_baddr_t a, input pch_byte_t d,
                                         input logic f);
    map_byte = (a == `PCH_STATE_BYTE) ? {7'h00, f} : d;
  endfunction

  pch_state_t state;
  logic [23:0] slot_cnt;
  logic [11:0] mask_cnt;
  logic acc, bit_ev, bit_val;
  logic [2:0] zrun;
  logic [4:0] orun;
  logic armed;
  logic [1:0] hist;
  logic frame_go;
  logic [1:0] bit_pos;
  logic [4:0] dcnt, len;
  logic [15:0] pay;
  logic [2:0] crc, rx_crc, crc_fin;
  pch_word_t words [3];
  logic [1:0] nwords, idx;
  logic [2:0] sa, fc;
  logic [5:0] ptr;
  pch_baddr_t byte_a, byte_b;
  logic fc_short, is_write, own, crc_ok, in_range;
  logic dec_reply, dec_write, dec_fetch, dec_enter, dec_burn;
  logic [3:0] dec_err;
  pch_word_t dec_rd1;
  logic burn_wait;
  logic [23:0] burn_dly;
  logic burn_go;

  pch_mem_if mem_if();

  pch_shadow_mem u_mem (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .bus(mem_if)
  );

  // Masked or burning-time sync pulses are not bits
  assign acc = i_sync_pulse && (mask_cnt == 12'h000) && !o_burning;
  assign bit_ev = acc || (slot_cnt == ZERO_W);
  assign bit_val = acc;

  // Bit slot timer: a slot with no sync by 1.5 periods is a zero
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      slot_cnt <= 24'h000000;
      mask_cnt <= 12'h000;
    end else if (acc) begin
      slot_cnt <= 24'h000000;
      mask_cnt <= MASK_W;
    end else begin
      slot_cnt <= (slot_cnt == ZERO_W) ? HALF_W : slot_cnt + 24'h000001;
      if (mask_cnt != 12'h000) begin
        mask_cnt <= mask_cnt - 12'h001;
      end
    end
  end

  // Start condition hunt
  assign frame_go = (state == ST_HUNT) && bit_ev && armed &&
                    ({hist, bit_val} == `PCH_START_BITS);
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      zrun <= 3'h0;
      orun <= 5'h00;
      armed <= 1'b0;
      hist <= 2'h0;
    end else if (state != ST_HUNT) begin
      zrun <= 3'h0;
      orun <= 5'h00;
      armed <= 1'b0;
      hist <= 2'h0;
    end else if (bit_ev) begin
      zrun <= bit_val ? 3'h0 : ((zrun == `PCH_ZERO_RUN) ? zrun : zrun + 3'h1);
      orun <= !bit_val ? 5'h00 : ((orun == `PCH_ONE_RUN) ? orun : orun + 5'h01);
      if ((!bit_val && zrun >= `PCH_ZERO_RUN - 3'h1) ||
          (bit_val && orun >= `PCH_ONE_RUN - 5'h01)) begin
        armed <= 1'b1;
      end
      hist <= {hist[0], bit_val};
    end
  end

  // Field decode of the stripped frame
  assign sa = pay[2:0];
  assign fc = pay[5:3];
  assign ptr = pay[11:6];
  assign byte_a = ptr[4:1];
  assign byte_b = byte_a + 4'h1;
  assign fc_short = fc[2];
  assign is_write = (fc == `PCH_FC_WRITE);
  assign own = (sa == `PCH_OWN_ADDR);
  assign crc_fin = crc_step(crc_step(crc_step(crc, 1'b0), 1'b0), 1'b0);
  assign crc_ok = (crc_fin == rx_crc);
  assign in_range = (ptr[5:1] < `PCH_NVM_BYTES);

  always_comb begin
    dec_reply = 1'b0;
    dec_err = 4'h0;
    dec_write = 1'b0;
    dec_fetch = 1'b0;
    dec_enter = 1'b0;
    dec_burn = 1'b0;
    dec_rd1 = 10'h000;
    if (fc_short) begin
      if (fc == `PCH_FC_ENTER) begin
        if (crc_ok && own) begin
          dec_enter = 1'b1;
          dec_reply = 1'b1;
          dec_rd1 = `PCH_ENTER_ACK;
        end
      end else if (fc == `PCH_FC_BURN && o_prog_mode) begin
        if (!crc_ok) begin
          dec_reply = 1'b1;
          dec_err = `PCH_ERR_CRC;
        end else if (own) begin
          dec_reply = 1'b1;
          if (i_array_locked) begin
            dec_err = `PCH_ERR_LOCK;
          end else begin
            dec_burn = 1'b1;
            dec_rd1 = `PCH_BURN_ACK;
          end
        end
      end
    end else if (o_prog_mode && (fc == `PCH_FC_READ || is_write)) begin
      if (!crc_ok) begin
        dec_reply = 1'b1;
        dec_err = `PCH_ERR_CRC;
      end else if (own) begin
        dec_reply = 1'b1;
        if (!in_range) begin
          dec_err = `PCH_ERR_RANGE;
        end else if (is_write && (i_array_locked || byte_a == `PCH_STATE_BYTE)) begin
          dec_err = `PCH_ERR_LOCK;
        end else begin
          dec_fetch = 1'b1;
          dec_write = is_write;
        end
      end
    end
  end

  assign mem_if.rd_addr = (state == ST_FETCH1) ? byte_b : byte_a;
  assign mem_if.wr_en = (state == ST_DECIDE) && dec_write;
  assign mem_if.wr_addr = byte_a;
  assign mem_if.wr_hi = ptr[0];
  assign mem_if.wr_nib = pay[15:12];
  assign mem_if.ld_en = i_load_valid;
  assign mem_if.ld_addr = i_load_addr;
  assign mem_if.ld_data = i_load_data;

  // Command sequencer
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state <= ST_HUNT;
      bit_pos <= 2'h0;
      dcnt <= 5'h00;
      len <= `PCH_LONG_BITS;
      pay <= 16'h0000;
      crc <= `PCH_CRC_SEED;
      rx_crc <= 3'h0;
      words <= '{default: 10'h000};
      nwords <= 2'h0;
      idx <= 2'h0;
    end else begin
      case (state)
        ST_HUNT: begin
          if (frame_go) begin
            state <= ST_FRAME;
            bit_pos <= 2'h0;
            dcnt <= 5'h00;
            len <= `PCH_LONG_BITS;
            pay <= 16'h0000;
            crc <= `PCH_CRC_SEED;
            rx_crc <= 3'h0;
          end
        end
        ST_FRAME: begin
          if (bit_ev && bit_pos == 2'h0) begin
            bit_pos <= 2'h1;
            if (!bit_val) begin
              words[0] <= `PCH_RC_ERR;
              words[1] <= {6'h00, `PCH_ERR_FRAME};
              nwords <= `PCH_SHORT_WORDS;
              idx <= 2'h0;
              state <= ST_REPLY;
            end
          end else if (bit_ev) begin
            bit_pos <= bit_pos + 2'h1;
            if (dcnt < len - `PCH_CRC_BITS) begin
              pay[dcnt[3:0]] <= bit_val;
              crc <= crc_step(crc, bit_val);
            end else begin
              rx_crc <= {rx_crc[1:0], bit_val};
            end
            dcnt <= dcnt + 5'h01;
            if (dcnt == `PCH_FC_POS) begin
              if (bit_val) begin
                len <= `PCH_SHORT_BITS;
              end else if (!pay[4]) begin
                state <= ST_HUNT;
              end
            end
            if (dcnt + 5'h01 == len) begin
              state <= ST_DECIDE;
            end
          end
        end
        ST_DECIDE: begin
          if (!dec_reply) begin
            state <= ST_HUNT;
          end else begin
            words[0] <= (dec_err != 4'h0) ? `PCH_RC_ERR : `PCH_RC_OK;
            words[1] <= (dec_err != 4'h0) ? {6'h00, dec_err} : dec_rd1;
            words[2] <= 10'h000;
            nwords <= fc_short ? `PCH_SHORT_WORDS : `PCH_LONG_WORDS;
            idx <= 2'h0;
            state <= dec_fetch ? ST_FETCH0 : ST_REPLY;
          end
        end
        ST_FETCH0: begin
          state <= ST_FETCH1;
        end
        ST_FETCH1: begin
          words[1] <= {2'h0, map_byte(byte_a, mem_if.rd_data, o_otp_load_done_flag)};
          state <= ST_FETCH2;
        end
        ST_FETCH2: begin
          if (is_write) begin
            words[2] <= {4'h0, ptr};
          end else if (byte_a == `PCH_STATE_BYTE) begin
            words[2] <= 10'h000;
          end else begin
            words[2] <= {2'h0, map_byte(byte_b, mem_if.rd_data, o_otp_load_done_flag)};
          end
          state <= ST_REPLY;
        end
        ST_REPLY: begin
          if (acc) begin
            idx <= idx + 2'h1;
            if (idx == nwords - 2'h1) begin
              state <= ST_HUNT;
            end
          end
        end
        default: begin
          state <= ST_HUNT;
        end
      endcase
    end
  end

  // One reply word per accepted sync pulse
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_resp_valid <= 1'b0;
      o_resp_word <= 10'h000;
    end else begin
      o_resp_valid <= (state == ST_REPLY) && acc;
      if ((state == ST_REPLY) && acc) begin
        o_resp_word <= words[idx];
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_prog_mode <= 1'b0;
    end else if (state == ST_DECIDE && dec_enter) begin
      o_prog_mode <= 1'b1;
    end
  end

  // Burn sequencing
  assign burn_go = (state == ST_DECIDE) && dec_burn;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      burn_wait <= 1'b0;
      burn_dly <= 24'h000000;
      o_burning <= 1'b0;
      o_burn_start <= 1'b0;
      o_refresh_req <= 1'b0;
    end else begin
      o_burn_start <= 1'b0;
      o_refresh_req <= 1'b0;
      if (burn_go) begin
        burn_wait <= 1'b1;
        burn_dly <= START_W;
      end else if (burn_wait) begin
        if (burn_dly == 24'h000000) begin
          burn_wait <= 1'b0;
          o_burning <= 1'b1;
          o_burn_start <= 1'b1;
        end else begin
          burn_dly <= burn_dly - 24'h000001;
        end
      end
      if (o_burning && i_burn_done) begin
        o_burning <= 1'b0;
        o_refresh_req <= i_burn_ok;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_otp_load_done_flag <= 1'b0;
    end else if (i_load_done) begin
      o_otp_load_done_flag <= 1'b1;
    end else if (burn_go) begin
      o_otp_load_done_flag <= 1'b0;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  sequence s_missing_sync;
    state == ST_FRAME && bit_ev && bit_pos == 2'h0 && !bit_val;
  endsequence
  sequence s_burn_accept;
    state == ST_DECIDE && dec_burn;
  endsequence

  a_crc_seed_load: assert property (frame_go |=> crc == `PCH_CRC_SEED)
    else $error("checksum not seeded at frame start");
  a_crc_fault_word: assert property (state == ST_DECIDE && dec_reply && !crc_ok
    |=> words[0] == `PCH_RC_ERR && words[1] == {6'h00, `PCH_ERR_CRC})
    else $error("checksum mismatch without fault 0010");
  a_sync_mask_hold: assert property (acc |=> (!acc) [*8])
    else $error("sync pulse accepted inside mask time");
  a_framing_reply: assert property (s_missing_sync |=> state == ST_REPLY
    && words[1] == {6'h00, `PCH_ERR_FRAME} && nwords == `PCH_SHORT_WORDS)
    else $error("missing sync bit not answered with framing fault");
  a_enter_mode: assert property (state == ST_DECIDE && dec_enter
    |=> o_prog_mode && words[1] == `PCH_ENTER_ACK)
    else $error("entry command did not enter programming mode");
  a_foreign_silent: assert property (state == ST_DECIDE && crc_ok && !own
    |=> state == ST_HUNT)
    else $error("foreign target address answered");
  a_reply_code: assert property (state == ST_REPLY && idx == 2'h0 && acc
    |=> o_resp_valid && (o_resp_word == `PCH_RC_OK || o_resp_word == `PCH_RC_ERR))
    else $error("first reply word not a reply code");
  a_burn_delay: assert property (s_burn_accept |=> (!o_burn_start) [*8])
    else $error("burn started without delay");
  a_last_byte_zero: assert property (state == ST_FETCH2 && !is_write
    && byte_a == `PCH_STATE_BYTE |=> words[2] == 10'h000)
    else $error("second byte after last address not zero");
  a_range_fault: assert property (state == ST_DECIDE && dec_reply && crc_ok && !in_range
    && !fc_short |=> words[1] == {6'h00, `PCH_ERR_RANGE})
    else $error("out of range pointer not faulted");
  a_decide_late: assert property (state == ST_DECIDE |-> $past(state) == ST_FRAME)
    else $error("decision before frame end");
  a_load_flag: assert property (i_load_done |=> o_otp_load_done_flag)
    else $error("load-done flag not set");
endmodule // pch_cmd_handler

// [pch_master_model.sv]
// Command master model: sends programming frames as supply sync pulses.
// Assumes the handler sees one-cycle pulses spaced by the bit period.
`timescale 1ns/1ps
module pch_master_model #(
  parameter int P_BIT = 2100
) (
  input wire logic i_clk, // System clock
  output logic o_sync // Sync pulse toward the handler
);
  initial o_sync = 1'b0;

  // A pulse is a one, a silent bit period is a zero
  task automatic put_bit(input logic b);
    @(posedge i_clk);
    o_sync <= b;
    @(posedge i_clk);
    o_sync <= 1'b0;
    repeat (P_BIT - 2) @(posedge i_clk);
  endtask

  task automatic syncs(input int n);
    repeat (n) put_bit(1'b1);
  endtask

  // Sync slot number cut is left silent and the frame stops there
  task automatic send_cmd(input logic [2:0] sa, fc, input logic [5:0] ptr,
                          input logic [3:0] dat, input bit lng, bad, input int cut);
    logic [18:0] d;
    logic [2:0] c;
    int n;
    n = lng ? 19 : 9;
    d = {3'h0, dat, ptr, fc, sa};
    c = 3'h7;
    for (int i = 0; i < n; i++) begin
      c = {c[1:0], (i < n - 3) ? d[i] : 1'b0} ^ (c[2] ? 3'h3 : 3'h0);
    end
    c = c ^ (bad ? 3'h1 : 3'h0);
    d[n - 3] = c[2];
    d[n - 2] = c[1];
    d[n - 1] = c[0];
    repeat (6 * P_BIT) @(posedge i_clk);
    put_bit(1'b0);
    put_bit(1'b1);
    put_bit(1'b0);
    for (int i = 0; i < n; i++) begin
      if (i % 3 == 0) begin
        if (i / 3 == cut) begin
          put_bit(1'b0);
          return;
        end
        put_bit(1'b1);
      end
      put_bit(d[i]);
    end
  endtask
endmodule // pch_master_model

// [pch_mem_if.sv]
// Carrier between the command handler and its shadow register memory.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface pch_mem_if;
  pch_pkg::pch_baddr_t rd_addr;
  pch_pkg::pch_byte_t rd_data;
  logic wr_en;
  pch_pkg::pch_baddr_t wr_addr;
  logic wr_hi;
  logic [3:0] wr_nib;
  logic ld_en;
  pch_pkg::pch_baddr_t ld_addr;
  pch_pkg::pch_byte_t ld_data;
  modport ctrl (output rd_addr, wr_en, wr_addr, wr_hi, wr_nib, ld_en, ld_addr, ld_data,
                input rd_data);
  modport mem (input rd_addr, wr_en, wr_addr, wr_hi, wr_nib, ld_en, ld_addr, ld_data,
               output rd_data);
endinterface : pch_mem_if

// [pch_pkg.sv]
// Types shared by the command handler, its shadow memory and their interface.
// Assumes nothing of its surroundings.
package pch_pkg;
  typedef logic [9:0] pch_word_t;
  typedef logic [7:0] pch_byte_t;
  typedef logic [3:0] pch_baddr_t;
  typedef enum logic [2:0] {
    ST_HUNT,
    ST_FRAME,
    ST_DECIDE,
    ST_FETCH0,
    ST_FETCH1,
    ST_FETCH2,
    ST_REPLY
  } pch_state_t;
endpackage

// [pch_shadow_mem.sv]
// Shadow register array: nibble writes, whole-byte loads, registered read data.
// Assumes one clock; a byte load wins over a nibble write to the same byte.
`timescale 1ns/1ps
module pch_shadow_mem (
  input wire logic i_clk, // System clock
  input wire logic i_rst_n, // Asynchronous reset, active low
  pch_mem_if.mem bus // Access port
);
  import pch_pkg::*;

  pch_byte_t mem [16];

  genvar g;
  generate
    for (g = 0; g < 16; g++) begin : g_byte
      always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          mem[g] <= 8'h00;
        end else if (bus.ld_en && bus.ld_addr == 4'(g)) begin
          mem[g] <= bus.ld_data;
        end else if (bus.wr_en && bus.wr_addr == 4'(g)) begin
          if (bus.wr_hi) begin
            mem[g][7:4] <= bus.wr_nib;
          end else begin
            mem[g][3:0] <= bus.wr_nib;
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      bus.rd_data <= 8'h00;
    end else begin
      bus.rd_data <= mem[bus.rd_addr];
    end
  end
endmodule // pch_shadow_mem

// [tb_pch_cmd_handler.sv]
// Self-checking bench of the programming-mode command handler.
// Assumes the master model drives the sync input and the bench the rest.
`timescale 1ns/1ps
`include "pch_cfg.svh"
module tb_pch_cmd_handler;
  import pch_pkg::*;
  localparam int P_BIT = 160;
  localparam int P_START = 20;
  localparam int P_MASK = 100;
  logic i_clk, i_rst_n, i_sync_pulse, i_array_locked, i_burn_done, i_burn_ok;
  logic i_load_valid, i_load_done;
  pch_baddr_t i_load_addr;
  pch_byte_t i_load_data;
  logic o_resp_valid, o_prog_mode, o_burn_start, o_burning, o_refresh_req;
  logic o_otp_load_done_flag;
  pch_word_t o_resp_word;
  pch_word_t got[$];
  int failures = 0;
  int n_checks = 0;
  int n_starts = 0;
  int n_refresh = 0;

  pch_cmd_handler #(.P_BIT_CYC(P_BIT), .P_START_CYC(P_START), .P_MASK_CYC(P_MASK)) uut (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_sync_pulse(i_sync_pulse),
    .i_array_locked(i_array_locked), .i_burn_done(i_burn_done), .i_burn_ok(i_burn_ok),
    .i_load_valid(i_load_valid), .i_load_addr(i_load_addr), .i_load_data(i_load_data),
    .i_load_done(i_load_done), .o_resp_valid(o_resp_valid), .o_resp_word(o_resp_word),
    .o_prog_mode(o_prog_mode), .o_burn_start(o_burn_start), .o_burning(o_burning),
    .o_refresh_req(o_refresh_req), .o_otp_load_done_flag(o_otp_load_done_flag));

  pch_master_model #(.P_BIT(P_BIT)) master (.i_clk(i_clk), .o_sync(i_sync_pulse));

  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  // Registered pulses are caught at the edge after they rise
  always @(posedge i_clk) begin
    if (o_resp_valid === 1'b1) got.push_back(o_resp_word);
    if (o_burn_start === 1'b1) n_starts++;
    if (o_refresh_req === 1'b1) n_refresh++;
  end

  task automatic check(input logic [15:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic cmp_words(input int nw, input pch_word_t w0, w1, w2);
    repeat (4) @(posedge i_clk);
    check(16'(got.size()), 16'(nw));
    for (int k = 0; k < nw && k < got.size(); k++) begin
      check({6'h0, got[k]}, {6'h0, (k == 0) ? w0 : (k == 1) ? w1 : w2});
    end
  endtask

  task automatic run_cmd(input logic [2:0] sa, fc, input logic [5:0] ptr,
                         input logic [3:0] dat, input bit lng, bad, input int cut, ns,
                         input int nw, input pch_word_t w0, w1, w2);
    got.delete();
    master.send_cmd(sa, fc, ptr, dat, lng, bad, cut);
    master.syncs(ns);
    cmp_words(nw, w0, w1, w2);
  endtask

  initial begin
    i_rst_n = 1'b0;
    i_array_locked = 1'b0;
    i_burn_done = 1'b0;
    i_burn_ok = 1'b0;
    i_load_valid = 1'b0;
    i_load_addr = 4'h0;
    i_load_data = 8'h00;
    i_load_done = 1'b0;
    repeat (6) @(posedge i_clk);
    i_rst_n <= 1'b1;
    @(posedge i_clk);
    check({o_prog_mode, o_burning, o_otp_load_done_flag, o_resp_valid}, 16'h0000);
    run_cmd(3'h2, 3'h7, 6'h00, 4'h0, 0, 0, -1, 2, 0, 0, 0, 0);
    check(o_prog_mode, 16'h0000);
    run_cmd(3'h1, 3'h7, 6'h00, 4'h0, 0, 0, -1, 2, 2, `PCH_RC_OK, `PCH_ENTER_ACK, 0);
    check(o_prog_mode, 16'h0001);
    run_cmd(3'h1, 3'h3, 6'h03, 4'hA, 1, 0, -1, 3, 3, `PCH_RC_OK, 10'h0A0, 10'h003);
    @(posedge i_clk);
    i_load_valid <= 1'b1;
    i_load_addr <= 4'h2;
    i_load_data <= 8'h5C;
    @(posedge i_clk);
    i_load_valid <= 1'b0;
    run_cmd(3'h1, 3'h2, 6'h02, 4'h0, 1, 0, -1, 3, 3, `PCH_RC_OK, 10'h0A0, 10'h05C);
    run_cmd(3'h1, 3'h2, 6'h02, 4'h0, 1, 1, -1, 3, 3, `PCH_RC_ERR, 10'h002, 0);
    run_cmd(3'h1, 3'h2, 6'h28, 4'h0, 1, 0, -1, 3, 3, `PCH_RC_ERR, 10'h005, 0);
    @(posedge i_clk);
    i_array_locked <= 1'b1;
    run_cmd(3'h1, 3'h3, 6'h00, 4'h3, 1, 0, -1, 3, 3, `PCH_RC_ERR, 10'h006, 0);
    i_array_locked <= 1'b0;
    run_cmd(3'h1, 3'h7, 6'h00, 4'h0, 0, 0, 1, 2, 2, `PCH_RC_ERR, 10'h001, 0);
    for (int f = 0; f < 4; f++) begin
      run_cmd(3'h1, 3'(f < 2 ? f : f + 3), 6'h00, 4'h0, f < 2, 0, -1, 3, 0, 0, 0, 0);
    end
    // The array is unlocked again above, so the burn may be requested now
    got.delete();
    master.send_cmd(3'h1, 3'h4, 6'h00, 4'h0, 0, 0, -1);
    for (int k = 0; k < 3 * P_BIT && o_burning !== 1'b1; k++) @(posedge i_clk);
    if (o_burning !== 1'b1) failures++;
    // A sync pulse while burning must not release a reply word
    master.syncs(1);
    check(16'(got.size()), 16'h0000);
    check(16'(n_starts), 16'h0001);
    @(posedge i_clk);
    i_burn_done <= 1'b1;
    i_burn_ok <= 1'b1;
    @(posedge i_clk);
    i_burn_done <= 1'b0;
    repeat (3) @(posedge i_clk);
    check({o_burning, 8'(n_refresh)}, 16'h0001);
    i_load_done <= 1'b1;
    @(posedge i_clk);
    i_load_done <= 1'b0;
    repeat (2) @(posedge i_clk);
    check(o_otp_load_done_flag, 16'h0001);
    master.syncs(2);
    cmp_words(2, `PCH_RC_OK, `PCH_BURN_ACK, 0);
    run_cmd(3'h1, 3'h2, 6'h1E, 4'h0, 1, 0, -1, 3, 3, `PCH_RC_OK, 10'h001, 10'h000);
    report_and_stop();
  end
endmodule // tb_pch_cmd_handler
